// *** mac_dma_pointers_and_stats.sv ***
// dma head/completion pointers, channel interrupts and receive frame statistics
// assumes an APB master on pclk and dma/receive logic on the same clock
`default_nettype none

module mac_dma_pointers_and_stats (
    // clock and reset
    input  wire logic                                   pclk,
    input  wire logic                                   presetn,
    // apb slave
    input  wire logic                                   psel,
    input  wire logic                                   penable,
    input  wire logic                                   pwrite,
    input  wire logic [mac_dma_stats_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [mac_dma_stats_pkg::DATA_W-1:0]   pwdata,
    input  wire logic [3:0]                             pstrb,
    output logic      [mac_dma_stats_pkg::DATA_W-1:0]   prdata,
    output logic                                        pready,
    output logic                                        pslverr,
    // descriptor completion from the dma engine
    input  wire logic                                   comp_valid,
    input  wire logic                                   comp_rx,
    input  wire logic [2:0]                             comp_chan,
    input  wire logic [31:0]                            comp_addr,
    input  wire logic [31:0]                            comp_next,
    // received frame summary from the receive path
    input  wire logic                                   frame_done,
    input  wire logic [15:0]                            frame_len,
    input  wire logic                                   frame_matched,
    input  wire logic                                   frame_crc_err,
    input  wire logic                                   frame_align_err,
    input  wire logic                                   frame_code_err,
    input  wire logic [47:0]                            frame_dest,
    input  wire logic                                   frame_overrun,
    // dma control
    output logic      [7:0]                             tx_queue_start,
    output logic      [7:0]                             rx_dma_armed,
    // interrupts
    output logic      [7:0]                             tx_chan_int,
    output logic      [7:0]                             rx_chan_int,
    output logic                                        statistics_interrupt_pending,
    output logic                                        irq
);
    import mac_dma_stats_pkg::*;

    // register state
    logic [31:0]        ptr_q [0:NUM_PTR-1];
    logic [31:0]        last_done [0:NUM_HEAD-1];
    logic [31:0]        stat_cnt [0:NUM_STATS-1];
    logic [31:0]        next_cnt [0:NUM_STATS-1];
    logic [1:0]         mac_control_register;
    logic [15:0]        max_receive_frame_length;
    logic [INT_W-1:0]   int_status;
    logic [INT_W-1:0]   int_mask;
    logic [5:0]         clear_count;
    logic               stats_ready;
    logic [15:0]        chan_int;
    logic [15:0]        start_pulse;
    logic [15:0]        armed;
    logic [31:0]        read_mux;

    // bus decode
    wire logic          setup_phase  = psel & ~penable;
    wire logic          bus_write    = psel & penable & pready & pwrite & ~pslverr;
    wire logic [4:0]    ptr_index    = paddr[6:2];
    wire logic [1:0]    stat_index   = paddr[3:2];
    wire logic          aligned      = (paddr[1:0] == 2'h0);
    wire logic          ptr_hit      = aligned & (paddr < PTR_SPAN);
    wire logic          head_hit     = ptr_hit & (ptr_index < 5'(NUM_HEAD));
    wire logic          stat_hit     = aligned & (paddr[11:4] == OFS_STAT_BASE[11:4])
                                       & (stat_index < 2'(NUM_STATS));
    wire logic          ctl_hit      = (paddr == OFS_MAC_CONTROL);
    wire logic          len_hit      = (paddr == OFS_MAX_LEN);
    wire logic          status_hit   = (paddr == OFS_INT_STATUS);
    wire logic          mask_hit     = (paddr == OFS_INT_MASK);
    wire logic          sstat_hit    = (paddr == OFS_STATS_STATUS);
    wire logic          mapped       = ptr_hit | stat_hit | ctl_hit | len_hit
                                       | status_hit | mask_hit | sstat_hit;
    wire logic          narrow_stat  = stat_hit & pwrite & (pstrb != FULL_STROBE);
    wire logic          refuse       = ~mapped | narrow_stat;

    // register write strobes
    wire logic          ptr_write    = bus_write & ptr_hit;
    wire logic          head_busy    = (ptr_q[ptr_index] != PTR_RESET);
    wire logic          head_accept  = ptr_write & head_hit & ~head_busy;
    wire logic          head_error   = ptr_write & head_hit & head_busy;
    wire logic          stat_write   = bus_write & stat_hit;
    wire logic          ctl_write    = bus_write & ctl_hit;
    wire logic          len_write    = bus_write & len_hit;
    wire logic          status_write = bus_write & status_hit;
    wire logic          mask_write   = bus_write & mask_hit;
    wire logic          gig_enable   = mac_control_register[CTL_GIG_EN_BIT];
    wire logic          stat_ie      = mac_control_register[CTL_STAT_IE_BIT];

    // receive frame classification
    wire logic          frame_err    = frame_crc_err | frame_align_err | frame_code_err;
    wire logic          len_ok       = (frame_len >= MIN_FRAME_LEN)
                                       & (frame_len <= max_receive_frame_length);
    // overrun flag deliberately not part of the qualification
    wire logic          good_frame   = frame_done & frame_matched & len_ok & ~frame_err;
    wire logic          dest_bcast   = (frame_dest == {48{1'b1}});
    wire logic          dest_group   = frame_dest[0];
    wire logic          bcast_frame  = good_frame & dest_bcast;
    wire logic          mcast_frame  = good_frame & dest_group & ~dest_bcast;
    wire logic [NUM_STATS-1:0] stat_inc = {mcast_frame, bcast_frame, good_frame};

    // counter events
    logic [NUM_STATS-1:0] wrap_hit;
    logic [NUM_STATS-1:0] over_half;
    wire logic          any_wrap     = |wrap_hit;
    wire logic          any_over     = |over_half;

    wire logic [INT_W-1:0] int_events = {frame_overrun, any_wrap, head_error};
    wire logic [INT_W-1:0] int_clear  = status_write ? pwdata[INT_W-1:0] : {INT_W{1'b0}};
    wire logic [INT_W-1:0] next_int_status = (int_status & ~int_clear) | int_events;

    // read data selection
    always_comb
    begin
        read_mux = 32'h0000_0000;
        if (ptr_hit)
        begin
            read_mux = ptr_q[ptr_index];
        end
        else if (stat_hit)
        begin
            read_mux = stat_cnt[stat_index];
        end
        else if (ctl_hit)
        begin
            read_mux = {30'h0000_0000, mac_control_register};
        end
        else if (len_hit)
        begin
            read_mux = {16'h0000, max_receive_frame_length};
        end
        else if (status_hit)
        begin
            read_mux = {29'h0000_0000, int_status};
        end
        else if (mask_hit)
        begin
            read_mux = {29'h0000_0000, int_mask};
        end
        else if (sstat_hit)
        begin
            read_mux = {30'h0000_0000, statistics_interrupt_pending, stats_ready};
        end
    end

    // apb answer: one wait-free access phase, data captured in setup
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= setup_phase;
            pslverr <= setup_phase & refuse;
            prdata  <= (setup_phase & ~pwrite & ~refuse) ? read_mux : 32'h0000_0000;
        end
    end

    // control registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mac_control_register     <= CTL_RESET;
            max_receive_frame_length <= MAX_LEN_RESET;
            int_mask                 <= INT_RESET;
            int_status               <= INT_RESET;
            irq                      <= 1'b0;
        end
        else
        begin
            if (ctl_write)
            begin
                mac_control_register <= pwdata[1:0];
            end
            if (len_write)
            begin
                max_receive_frame_length <= pwdata[15:0];
            end
            if (mask_write)
            begin
                int_mask <= pwdata[INT_W-1:0];
            end
            int_status <= next_int_status;
            irq        <= |(next_int_status & int_mask);
        end
    end

    // pointer registers: heads 0-15, completion pointers 16-31
    genvar i;
    generate
        for (i = 0; i < NUM_PTR; i++)
        begin : g_ptr
            localparam logic [4:0] IDX     = 5'(i);
            localparam bit         IS_HEAD = (i < NUM_HEAD);
            localparam bit         IS_RX   = ((i / NUM_CHAN) % 2) == 1;
            localparam logic [2:0] CH      = 3'(i % NUM_CHAN);
            wire logic sel      = ptr_write & (ptr_index == IDX);
            wire logic done_hit = IS_HEAD & comp_valid & (comp_rx == IS_RX) & (comp_chan == CH);

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    ptr_q[i] <= PTR_RESET;
                end
                else if (sel & (!IS_HEAD | ~head_busy))
                begin
                    ptr_q[i] <= pwdata;
                end
                else if (done_hit)
                begin
                    ptr_q[i] <= comp_next;
                end
            end
        end
    endgenerate

    // per-channel start, arming and completion interrupt
    genvar j;
    generate
        for (j = 0; j < NUM_HEAD; j++)
        begin : g_chan
            localparam logic [4:0] HEAD_IDX = 5'(j);
            localparam logic [4:0] COMP_IDX = 5'(j + NUM_HEAD);
            localparam bit         IS_RX    = (j >= NUM_CHAN);
            localparam logic [2:0] CH       = 3'(j % NUM_CHAN);
            wire logic done_hit  = comp_valid & (comp_rx == IS_RX) & (comp_chan == CH);
            wire logic cp_match  = ptr_write & (ptr_index == COMP_IDX) & (pwdata == last_done[j]);
            wire logic started   = head_accept & (ptr_index == HEAD_IDX);

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    last_done[j]   <= PTR_RESET;
                    chan_int[j]    <= 1'b0;
                    start_pulse[j] <= 1'b0;
                    armed[j]       <= 1'b0;
                end
                else
                begin
                    if (done_hit)
                    begin
                        last_done[j] <= comp_addr;
                    end
                    // new completion wins over a release in the same cycle
                    if (done_hit)
                    begin
                        chan_int[j] <= 1'b1;
                    end
                    else if (cp_match)
                    begin
                        chan_int[j] <= 1'b0;
                    end
                    start_pulse[j] <= started;
                    armed[j]       <= (ptr_q[j] != PTR_RESET) | started;
                end
            end
        end
    endgenerate

    assign tx_queue_start = start_pulse[NUM_CHAN-1:0];
    assign rx_dma_armed   = armed[NUM_HEAD-1:NUM_CHAN];
    assign tx_chan_int    = chan_int[NUM_CHAN-1:0];
    assign rx_chan_int    = chan_int[NUM_HEAD-1:NUM_CHAN];

    // statistics clear sweep after reset release
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            clear_count <= 6'h00;
            stats_ready <= 1'b0;
        end
        else if (!stats_ready)
        begin
            clear_count <= clear_count + 6'h01;
            stats_ready <= (clear_count == STAT_CLEAR_LAST);
        end
    end

    // statistics counters
    genvar k;
    generate
        for (k = 0; k < NUM_STATS; k++)
        begin : g_stat
            localparam logic [1:0] SIDX = 2'(k);
            wire logic        hit    = stat_write & (stat_index == SIDX);
            wire logic [31:0] counted = stat_cnt[k] + {31'h0000_0000, stat_inc[k]};

            assign wrap_hit[k]  = stat_inc[k] & (stat_cnt[k] == 32'hFFFF_FFFF);
            assign over_half[k] = (stat_cnt[k] >= STAT_THRESHOLD);

            always_comb
            begin
                next_cnt[k] = counted;
                if (!stats_ready)
                begin
                    next_cnt[k] = STAT_RESET;
                end
                else if (hit & gig_enable)
                begin
                    next_cnt[k] = (counted > pwdata) ? (counted - pwdata) : STAT_RESET;
                end
                else if (hit)
                begin
                    next_cnt[k] = pwdata + {31'h0000_0000, stat_inc[k]};
                end
            end

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    stat_cnt[k] <= STAT_RESET;
                end
                else
                begin
                    stat_cnt[k] <= next_cnt[k];
                end
            end
        end
    endgenerate

    // level statistics interrupt follows the counters
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            statistics_interrupt_pending <= 1'b0;
        end
        else
        begin
            statistics_interrupt_pending <= stat_ie & any_over;
        end
    end

endmodule // mac_dma_pointers_and_stats

`default_nettype wire

// *** mac_dma_stats_pkg.sv ***
// constants shared by the dma pointer and statistics block
// assumes a single pclk domain and a 12-bit APB byte address
`default_nettype none

package mac_dma_stats_pkg;

    // apb bus geometry
    localparam int          ADDR_W            = 12;
    localparam int          DATA_W            = 32;
    localparam logic [3:0]  FULL_STROBE       = 4'hF;

    // register byte offsets
    localparam logic [11:0] OFS_TX_HEAD       = 12'h000;
    localparam logic [11:0] OFS_RX_HEAD       = 12'h020;
    localparam logic [11:0] OFS_TX_COMP       = 12'h040;
    localparam logic [11:0] OFS_RX_COMP       = 12'h060;
    localparam logic [11:0] PTR_SPAN          = 12'h080;
    localparam logic [11:0] OFS_MAC_CONTROL   = 12'h080;
    localparam logic [11:0] OFS_MAX_LEN       = 12'h084;
    localparam logic [11:0] OFS_INT_STATUS    = 12'h088;
    localparam logic [11:0] OFS_INT_MASK      = 12'h08C;
    localparam logic [11:0] OFS_STATS_STATUS  = 12'h090;
    localparam logic [11:0] OFS_STAT_BASE     = 12'h100;

    // channel and pointer geometry
    localparam int          NUM_CHAN          = 8;
    localparam int          NUM_PTR           = 32;
    localparam int          NUM_HEAD          = 16;
    localparam int          NUM_STATS         = 3;
    localparam int          STAT_GOOD         = 0;
    localparam int          STAT_BCAST        = 1;
    localparam int          STAT_MCAST        = 2;

    // mac control fields
    localparam int          CTL_GIG_EN_BIT    = 0;
    localparam int          CTL_STAT_IE_BIT   = 1;
    localparam logic [1:0]  CTL_RESET         = 2'h0;

    // interrupt status fields
    localparam int          INT_W             = 3;
    localparam int          INT_HEAD_ERR_BIT  = 0;
    localparam int          INT_WRAP_BIT      = 1;
    localparam int          INT_OVERRUN_BIT   = 2;
    localparam logic [2:0]  INT_RESET         = 3'h0;

    // frame length limits
    localparam logic [15:0] MIN_FRAME_LEN     = 16'h0040;
    localparam logic [15:0] MAX_LEN_RESET     = 16'h05EE;

    // statistics behaviour
    localparam logic [31:0] STAT_THRESHOLD    = 32'h8000_0000;
    localparam logic [31:0] PTR_RESET         = 32'h0000_0000;
    localparam logic [31:0] STAT_RESET        = 32'h0000_0000;
    localparam int          CLK_PERIOD_NS     = 10;
    localparam int          STAT_CLEAR_CYCLES = 38;
    localparam logic [5:0]  STAT_CLEAR_LAST   = 6'(STAT_CLEAR_CYCLES - 1);

endpackage : mac_dma_stats_pkg

`default_nettype wire

// *** mac_dma_stats_properties.sv ***
// concurrent checks on the ports of the pointer and statistics block
// assumes one pclk domain; bound from the testbench top file
`default_nettype none

module mac_dma_stats_properties (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    // completion and frame inputs
    input  wire logic        comp_valid,
    input  wire logic        comp_rx,
    input  wire logic [2:0]  comp_chan,
    input  wire logic        frame_done,
    // outputs under check
    input  wire logic [7:0]  tx_queue_start,
    input  wire logic [7:0]  rx_dma_armed,
    input  wire logic [7:0]  tx_chan_int,
    input  wire logic [7:0]  rx_chan_int,
    input  wire logic        statistics_interrupt_pending
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic      [5:0] since_rst;
    wire logic       wr_acc  = psel & penable & pwrite & pready;
    wire logic       wr_tx   = wr_acc & (paddr < 12'h020);
    wire logic       wr_rx   = wr_acc & (paddr >= 12'h020) & (paddr < 12'h040);
    wire logic       wr_cp   = wr_acc & (paddr >= 12'h040) & (paddr < 12'h080);
    wire logic       ctl_off = wr_acc & (paddr == 12'h080) & ~pwdata[1];
    wire logic       rd_stat = psel & penable & ~pwrite & pready & (paddr[11:8] == 4'h1);

    // cycles since reset release, saturating
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            since_rst <= 6'h00;
        else if (since_rst != 6'h3F)
            since_rst <= since_rst + 6'h01;
    end

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_one_beat;
        pready ##1 !pready;
    endsequence

    a_ready_one_beat: assert property (s_setup |=> s_one_beat)
        else $error("pready not a single beat after setup");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_start_has_cause: assert property (|tx_queue_start |-> $past(wr_tx) || $past(wr_tx, 2))
        else $error("queue start without head write");
    a_start_is_pulse: assert property (|tx_queue_start |=> tx_queue_start == 8'h00)
        else $error("queue start longer than one cycle");
    a_arm_has_cause: assert property ((rx_dma_armed & ~$past(rx_dma_armed)) != 8'h00
        |-> $past(wr_rx) || $past(wr_rx, 2)) else $error("rx armed without head write");
    a_int_on_comp: assert property (comp_valid |=>
        ((($past(comp_rx) ? rx_chan_int : tx_chan_int) >> $past(comp_chan)) & 8'h01) == 8'h01)
        else $error("channel interrupt not set by completion");
    a_int_clear_cause: assert property (($past({tx_chan_int, rx_chan_int}) & ~{tx_chan_int, rx_chan_int})
        != 16'h0000 |-> $past(wr_cp) || $past(wr_cp, 2)) else $error("channel interrupt fell unasked");
    a_zero_after_rst: assert property (rd_stat && since_rst < 6'h26 |-> prdata == 32'h0000_0000)
        else $error("counter nonzero during clear");
    a_pend_needs_en: assert property (ctl_off |=> ##1 !statistics_interrupt_pending)
        else $error("pending while disabled");
    a_pend_rise_cause: assert property ($rose(statistics_interrupt_pending) |-> $past(frame_done || wr_acc, 2))
        else $error("pending rose without cause");
    a_pend_fall_cause: assert property ($fell(statistics_interrupt_pending) |-> $past(frame_done || wr_acc, 2))
        else $error("pending fell without cause");
endmodule // mac_dma_stats_properties

`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the dma pointer and statistics block
// assumes the design package is compiled first; the checker is bound below
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import mac_dma_stats_pkg::*;

    localparam logic [47:0] UNI = 48'h0000_0000_1234;
    localparam logic [47:0] MC  = 48'h0000_5E00_0001;
    localparam logic [47:0] BC  = 48'hFFFF_FFFF_FFFF;

    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, comp_addr = 32'h0, comp_next = 32'h0, prdata, q, eg, eb, em;
    logic [3:0]  pstrb = 4'hF;
    logic [2:0]  comp_chan = 3'h0;
    logic        comp_valid = 1'b0, comp_rx = 1'b0, frame_done = 1'b0, frame_matched = 1'b0;
    logic        frame_crc_err = 1'b0, frame_align_err = 1'b0, frame_code_err = 1'b0, frame_overrun = 1'b0;
    logic [15:0] frame_len = 16'h0;
    logic [47:0] frame_dest = 48'h0;
    logic [7:0]  tx_queue_start, rx_dma_armed, tx_chan_int, rx_chan_int, started = 8'h00;
    logic        pready, pslverr, statistics_interrupt_pending, irq, clr_started = 1'b0;
    int          n_errors = 0, samples_checked = 0, cycles = 0;

    mac_dma_pointers_and_stats dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
        .comp_valid, .comp_rx, .comp_chan, .comp_addr, .comp_next, .frame_done, .frame_len,
        .frame_matched, .frame_crc_err, .frame_align_err, .frame_code_err, .frame_dest,
        .frame_overrun, .tx_queue_start, .rx_dma_armed, .tx_chan_int, .rx_chan_int,
        .statistics_interrupt_pending, .irq
    );

    always #5 pclk = ~pclk;

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // start-pulse collector and hang guard
    always @(posedge pclk)
    begin
        started <= clr_started ? 8'h00 : (started | tx_queue_start);
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            conclude();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 4'hF);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0, 4'hF);
        chk(q, e);
    endtask

    // f: overrun, code, align, crc, matched
    task automatic frm(input logic [15:0] l, input logic [4:0] f, input logic [47:0] d);
        @(posedge pclk);
        frame_done <= 1'b1;
        frame_len <= l;
        frame_dest <= d;
        {frame_overrun, frame_code_err, frame_align_err, frame_crc_err, frame_matched} <= f;
        if (f[0] && f[3:1] == 3'h0 && l >= MIN_FRAME_LEN && l <= MAX_LEN_RESET)
        begin
            eg++;
            if (d == BC)
                eb++;
            else if (d[0])
                em++;
        end
    endtask

    task automatic fend();
        @(posedge pclk);
        frame_done <= 1'b0;
        frame_overrun <= 1'b0;
    endtask

    function automatic logic ib(input logic r, input logic [2:0] c);
        return r ? rx_chan_int[c] : tx_chan_int[c];
    endfunction

    task automatic cmpl(input logic r, input logic [2:0] c);
        logic [11:0] cp;
        cp = (r ? OFS_RX_COMP : OFS_TX_COMP) + {7'h00, c, 2'h0};
        @(posedge pclk);
        comp_valid <= 1'b1;
        comp_rx <= r;
        comp_chan <= c;
        comp_addr <= 32'h0000_2000;
        @(posedge pclk);
        comp_valid <= 1'b0;
        #1 chk(32'(ib(r, c)), 32'h1);
        wr(cp, 32'h0000_2004);
        #1 chk(32'(ib(r, c)), 32'h1);
        wr(cp, 32'h0000_2000);
        #1 chk(32'(ib(r, c)), 32'h0);
        rdc(cp - 12'h040, 32'h0);
        rdc(cp, 32'h0000_2000);
    endtask

    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        wr(OFS_STAT_BASE, 32'h0000_0005);
        rdc(OFS_STAT_BASE, 32'h0);
        repeat (40) @(posedge pclk);
        rdc(OFS_STATS_STATUS, 32'h1);
        wr(OFS_STAT_BASE, 32'h0000_0005);
        rdc(OFS_STAT_BASE, 32'h0000_0005);
        $display("reset clear test done");
        for (int n = 0; n < 16; n++)
            wr(OFS_TX_HEAD + 12'(4 * n), 32'h0);
        clr_started <= 1'b1;
        @(posedge pclk);
        clr_started <= 1'b0;
        for (int n = 0; n < 8; n++)
        begin
            wr(OFS_TX_HEAD + 12'(4 * n), 32'h0000_1000 + 32'(n));
            wr(OFS_RX_HEAD + 12'(4 * n), 32'h0000_3000 + 32'(n));
            @(posedge pclk);
            #1 chk({24'h0, rx_dma_armed}, (32'h2 << n) - 32'h1);
            rdc(OFS_TX_HEAD + 12'(4 * n), 32'h0000_1000 + 32'(n));
        end
        chk({24'h0, started}, 32'h0000_00FF);
        clr_started <= 1'b1;
        @(posedge pclk);
        clr_started <= 1'b0;
        wr(OFS_TX_HEAD + 12'h004, 32'h0000_9999);
        chk(32'(err), 32'h0);
        rdc(OFS_TX_HEAD + 12'h004, 32'h0000_1001);
        chk({24'h0, started}, 32'h0);
        rdc(OFS_INT_STATUS, 32'h1);
        chk(32'(irq), 32'h0);
        wr(OFS_INT_MASK, 32'h1);
        @(posedge pclk);
        #1 chk(32'(irq), 32'h1);
        wr(OFS_INT_STATUS, 32'h1);
        @(posedge pclk);
        #1 chk(32'(irq), 32'h0);
        $display("head pointer test done");
        cmpl(1'b0, 3'h2);
        cmpl(1'b1, 3'h5);
        $display("completion test done");
        eg = 32'h0;
        eb = 32'h0;
        em = 32'h0;
        for (int n = 0; n < 3; n++)
            wr(OFS_STAT_BASE + 12'(4 * n), 32'h0);
        frm(16'h0040, 5'h01, UNI);
        frm(16'h003F, 5'h01, UNI);
        frm(16'h05EE, 5'h01, BC);
        frm(16'h05EF, 5'h01, BC);
        frm(16'h0040, 5'h03, MC);
        frm(16'h0040, 5'h05, MC);
        frm(16'h0040, 5'h09, MC);
        frm(16'h0040, 5'h00, MC);
        frm(16'h0100, 5'h01, MC);
        frm(16'h0100, 5'h11, BC);
        fend();
        rdc(OFS_STAT_BASE, eg);
        rdc(OFS_STAT_BASE + 12'h004, eb);
        rdc(OFS_STAT_BASE + 12'h008, em);
        rdc(OFS_INT_STATUS, 32'h4);
        wr(OFS_INT_STATUS, 32'h7);
        $display("frame count test done");
        wr(OFS_STAT_BASE, 32'hFFFF_FFFF);
        frm(16'h0040, 5'h01, UNI);
        fend();
        rdc(OFS_STAT_BASE, 32'h0);
        rdc(OFS_INT_STATUS, 32'h2);
        wr(OFS_STAT_BASE, 32'h8000_0000);
        repeat (3) @(posedge pclk);
        chk(32'(statistics_interrupt_pending), 32'h0);
        wr(OFS_MAC_CONTROL, 32'h2);
        repeat (3) @(posedge pclk);
        chk(32'(statistics_interrupt_pending), 32'h1);
        wr(OFS_MAC_CONTROL, 32'h3);
        wr(OFS_STAT_BASE, 32'h1);
        rdc(OFS_STAT_BASE, 32'h7FFF_FFFF);
        chk(32'(statistics_interrupt_pending), 32'h0);
        wr(OFS_STAT_BASE, 32'h8000_0000);
        rdc(OFS_STAT_BASE, 32'h0);
        wr(OFS_MAX_LEN, 32'h0000_0100);
        frm(16'h0101, 5'h01, UNI);
        frm(16'h0100, 5'h01, UNI);
        fend();
        rdc(OFS_STAT_BASE, 32'h1);
        xfer(1'b1, OFS_STAT_BASE + 12'h004, 32'h5, 4'h3);
        chk(32'(err), 32'h1);
        rdc(OFS_STAT_BASE + 12'h004, eb);
        xfer(1'b0, 12'hFFC, 32'h0, 4'hF);
        chk(32'(err), 32'h1);
        $display("counter mode test done");
        conclude();
    end
endmodule // tb_top

bind mac_dma_pointers_and_stats mac_dma_stats_properties u_props (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .comp_valid, .comp_rx, .comp_chan, .frame_done, .tx_queue_start, .rx_dma_armed,
    .tx_chan_int, .rx_chan_int, .statistics_interrupt_pending
);

`default_nettype wire
